// ### core/loader_defs.vh
// Constants for the program RAM loader: offsets, fields, resets, counts
`ifndef LOADER_DEFS_VH
`define LOADER_DEFS_VH

// Port register offsets (6-bit address space)
`define ADDR_LOAD_CTRL     6'h3F
`define ADDR_FW_REVISION   6'h3E
`define ADDR_MAIN_CONTROL  6'h00

// Load control fields
`define CTRL_RAM_SEL_BIT   3
`define CTRL_LOAD_EN_BIT   2
`define CTRL_WRITE_MASK    8'h0F
`define CTRL_RESET         8'h00

// Main control field
`define MC_SOFT_RESET_BIT  0

// Reset values
`define SIG_SEED           8'h00
`define DEV_REG_RESET      8'h00
`define FW_REV_RESET       8'h00

// Signature feedback taps: x^8 + x^4 + x^3 + x^2 + 1
`define SIG_POLY           8'h1D

// Program RAM size in bytes and counter width
`define RAM_BYTES          13'h1000
`define RAM_ADDR_W         12
`define FILL_CNT_W         13

// Fill buffer shape
`define FIFO_DEPTH         16
`define FIFO_AW            4

`endif

// ### core/fill_fifo.v
// Synchronous flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps

module fill_fifo
#(
  parameter WIDTH = 20,
  parameter DEPTH = 16,
  parameter AW    = 4
)
(
  // Clock and reset
  input  wire             clk_in,
  input  wire             rst_n_in,
  // Fill side
  input  wire             in_valid_in,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             in_ready_out,
  // Drain side
  output wire             out_valid_out,
  output wire [WIDTH-1:0] out_data_out,
  input  wire             out_ready_in
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;

  wire            push;
  wire            pop;

  // Full and empty come straight from the occupancy count
  assign in_ready_out  = (count_q != DEPTH[AW:0]);
  assign out_valid_out = (count_q != {(AW+1){1'b0}});
  assign out_data_out  = mem_q[rd_ptr_q];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // Pointers and count
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (push && !pop)
        count_q <= count_q + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        count_q <= count_q - {{AW{1'b0}}, 1'b1};
    end
  end

  // Storage needs no reset; only valid entries are ever read
  always @(posedge clk_in)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data_in;
  end

endmodule

// ### core/program_ram_loader.v
// Program RAM loader: load control, signature, fill path, device registers
`timescale 1ns/1ps
`include "loader_defs.vh"

// Behaviour
// - Load mode read with address bit 5 set returns control register.
// - Load mode read with address bit 5 clear returns load signature.
// - Outside load mode, writes go to the addressed device register.
// - Outside load mode, reads return the addressed device register.
// - Control 0000 runs ROM, counter and signature held ready.
// - Load-from-ROM state: each stored non-control write advances RAM address.
// - Load-from-ROM state: each stored non-control write folds into signature.
// - Control 1000 runs RAM, counter and signature back to ready.
// - Clearing load enable ends loading, resets signature and counter.
// - Hardware reset returns load logic to ready state.
// - Hardware reset selects ROM; software reset keeps RAM selection.
// - Firmware revision shows code of last program that initialised.
// - Fill write address ignored unless control; data at generated addr.
// - Only first 4096 fill writes per session are stored.
// - Reads in load mode leave fill address sequence untouched.
// - Signature is an 8-bit MISR fed only by fill writes.
module program_ram_loader
(
  // Clock and reset
  input  wire        clk_in,
  input  wire        rst_n_in,
  // Decoded port transactions from the serial front end
  input  wire        acc_valid_in,
  input  wire        acc_write_in,
  input  wire [5:0]  acc_addr_in,
  input  wire [7:0]  acc_wdata_in,
  output wire        acc_ready_out,
  output reg         rd_valid_out,
  output reg  [7:0]  rd_data_out,
  // Program RAM write port
  output wire        ram_we_out,
  output wire [11:0] ram_addr_out,
  output wire [7:0]  ram_data_out,
  input  wire        ram_ready_in,
  // Execution control towards the processor core
  output wire        ram_execute_select_out,
  output wire        load_enable_out,
  output reg         soft_reset_out,
  // Register initialisation report from the running program
  input  wire        init_done_in,
  input  wire [7:0]  fw_code_in,
  // Load progress visible to the rest of the chip
  output wire        ram_full_out
);

  // ********************************************************************
  // State
  // ********************************************************************

  localparam ST_ROM_IDLE = 2'b00;
  localparam ST_ROM_LOAD = 2'b01;
  localparam ST_RAM_RUN  = 2'b10;
  localparam ST_RAM_LOAD = 2'b11;

  reg  [7:0]  program_load_control_q;
  reg  [7:0]  load_signature_q;
  reg  [7:0]  load_signature_d;
  reg  [12:0] fill_count_q;
  reg  [7:0]  firmware_revision_q;
  reg  [7:0]  device_register_q [0:61];
  reg  [1:0]  mode;
  reg  [7:0]  rd_data_d;

  wire        load_mode;
  wire        acc_take;
  wire        is_ctrl_addr;
  wire        fill_write;
  wire        fill_store;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [19:0] fifo_out_data;
  wire        ctrl_write;
  wire        device_register_write;
  wire        mc_soft_reset;
  wire        load_falls;
  integer     i;

  // ********************************************************************
  // Decode
  // ********************************************************************

  // Mode taken from the two meaningful control bits
  always @*
  begin
    case ({program_load_control_q[`CTRL_RAM_SEL_BIT],
           program_load_control_q[`CTRL_LOAD_EN_BIT]})
      2'b00:   mode = ST_ROM_IDLE;
      2'b01:   mode = ST_ROM_LOAD;
      2'b10:   mode = ST_RAM_RUN;
      2'b11:   mode = ST_RAM_LOAD;
      default: mode = ST_ROM_IDLE;
    endcase
  end

  // RAM-run-while-loading is host misuse; it behaves as a load
  assign load_mode    = (mode == ST_ROM_LOAD) | (mode == ST_RAM_LOAD);
  assign is_ctrl_addr = (acc_addr_in == `ADDR_LOAD_CTRL);
  assign acc_take     = acc_valid_in & acc_ready_out;

  // Any write off the control address is a fill write in load mode
  assign fill_write   = acc_take & acc_write_in & load_mode
                        & ~is_ctrl_addr;
  // Past the RAM size fills are acknowledged but dropped
  assign fill_store   = fill_write
                        & (fill_count_q != `RAM_BYTES);
  assign ram_full_out = (fill_count_q == `RAM_BYTES);

  // Stall only a fill that would be stored while the buffer is full
  assign acc_ready_out = ~(acc_valid_in & acc_write_in & load_mode
                           & ~is_ctrl_addr
                           & (fill_count_q != `RAM_BYTES)
                           & ~fifo_in_ready);

  assign ctrl_write    = acc_take & acc_write_in & is_ctrl_addr;
  assign device_register_write    = acc_take & acc_write_in & ~load_mode
                         & ~is_ctrl_addr
                         & (acc_addr_in != `ADDR_FW_REVISION);
  assign mc_soft_reset = device_register_write
                         & (acc_addr_in == `ADDR_MAIN_CONTROL)
                         & acc_wdata_in[`MC_SOFT_RESET_BIT];
  assign load_falls    = ctrl_write & load_mode
                         & ~acc_wdata_in[`CTRL_LOAD_EN_BIT];

  assign ram_execute_select_out =
    program_load_control_q[`CTRL_RAM_SEL_BIT];
  assign load_enable_out = load_mode;

  // ********************************************************************
  // Load control register
  // ********************************************************************

  // Writable in both modes; of the two resets only hardware reset returns it to ROM
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      program_load_control_q <= `CTRL_RESET;
    else if (ctrl_write)
      program_load_control_q <= acc_wdata_in & `CTRL_WRITE_MASK;
  end

  // ********************************************************************
  // Fill address counter and signature
  // ********************************************************************

  // MISR step: shift, feed back top bit through taps, fold in data
  always @*
  begin
    load_signature_d = {load_signature_q[6:0], 1'b0}
                       ^ (load_signature_q[7] ? `SIG_POLY : 8'h00)
                       ^ acc_wdata_in;
  end

  // Held at ready whenever loading is off; reads never touch them
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fill_count_q     <= {`FILL_CNT_W{1'b0}};
      load_signature_q <= `SIG_SEED;
    end
    else if (!load_mode)
    begin
      fill_count_q     <= {`FILL_CNT_W{1'b0}};
      load_signature_q <= `SIG_SEED;
    end
    else if (load_falls)
    begin
      fill_count_q     <= {`FILL_CNT_W{1'b0}};
      load_signature_q <= `SIG_SEED;
    end
    else if (fill_store)
    begin
      fill_count_q     <= fill_count_q + 13'h0001;
      load_signature_q <= load_signature_d;
    end
  end

  // ********************************************************************
  // Fill buffer towards program RAM
  // ********************************************************************

  // Decouples the port from a RAM port that may stall on core fetches
  fill_fifo
  #(
    .WIDTH (20),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  )
  u_fill_fifo
  (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (fill_store),
    .in_data_in    ({fill_count_q[11:0], acc_wdata_in}),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out_data),
    .out_ready_in  (ram_ready_in)
  );

  assign ram_we_out   = fifo_out_valid;
  assign ram_addr_out = fifo_out_data[19:8];
  assign ram_data_out = fifo_out_data[7:0];

  // ********************************************************************
  // Device registers, firmware revision, software reset
  // ********************************************************************

  // Software reset restores defaults but leaves load control alone
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      for (i = 0; i < 62; i = i + 1)
        device_register_q[i] <= `DEV_REG_RESET;
    end
    else if (soft_reset_out)
    begin
      for (i = 0; i < 62; i = i + 1)
        device_register_q[i] <= `DEV_REG_RESET;
    end
    else if (device_register_write)
      device_register_q[acc_addr_in] <= acc_wdata_in;
  end

  // Soft reset bit is self clearing: a one-cycle pulse to the core
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      soft_reset_out <= 1'b0;
    else
      soft_reset_out <= mc_soft_reset;
  end

  // Captured each time a program finishes register initialisation
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      firmware_revision_q <= `FW_REV_RESET;
    else if (init_done_in)
      firmware_revision_q <= fw_code_in;
  end

  // ********************************************************************
  // Read path
  // ********************************************************************

  // Read source selection by mode and address
  always @*
  begin
    if (load_mode)
    begin
      if (acc_addr_in[5])
        rd_data_d = program_load_control_q;
      else
        rd_data_d = load_signature_q;
    end
    else if (is_ctrl_addr)
      rd_data_d = program_load_control_q;
    else if (acc_addr_in == `ADDR_FW_REVISION)
      rd_data_d = firmware_revision_q;
    else
      rd_data_d = device_register_q[acc_addr_in];
  end

  // Read answer one cycle after the request; no load state changes
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= 8'h00;
    end
    else
    begin
      rd_valid_out <= acc_take & ~acc_write_in;
      if (acc_take && !acc_write_in)
        rd_data_out <= rd_data_d;
    end
  end

endmodule

// ### verification/loader_monitor.sv
// Port checker for the program RAM loader
`timescale 1ns/1ps

module loader_monitor
(
  // Clock and reset
  input wire        clk_in,
  input wire        rst_n_in,
  // Port and RAM side
  input wire        acc_valid_in,
  input wire        acc_write_in,
  input wire [5:0]  acc_addr_in,
  input wire [7:0]  acc_wdata_in,
  input wire        acc_ready_out,
  input wire        rd_valid_out,
  input wire        ram_we_out,
  input wire        ram_ready_in,
  input wire [11:0] ram_addr_out,
  // Control outputs
  input wire        load_enable_out,
  input wire        ram_execute_select_out,
  input wire        soft_reset_out,
  input wire        ram_full_out
);
  // ****
  // Taken requests, decoded once
  // ****
  wire take   = acc_valid_in & acc_ready_out;
  wire ctl_wr = take & acc_write_in & (acc_addr_in == 6'h3F);

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_read_answer:
    assert property (take && !acc_write_in |=> rd_valid_out)
    else $error("read not answered");
  chk_load_bit:
    assert property (ctl_wr |=> load_enable_out == $past(acc_wdata_in[2]))
    else $error("load bit wrong");
  chk_ram_select:
    assert property (ctl_wr |=>
      ram_execute_select_out == $past(acc_wdata_in[3]))
    else $error("ram select wrong");
  chk_fill_stall:
    assert property (!acc_ready_out |-> acc_valid_in && acc_write_in &&
      load_enable_out && acc_addr_in != 6'h3F)
    else $error("bad refusal");
  chk_ram_hold:
    assert property (ram_we_out && !ram_ready_in |=>
      ram_we_out && $stable(ram_addr_out))
    else $error("ram write dropped");
  chk_full_keep:
    assert property (ram_full_out && !ctl_wr |=> ram_full_out)
    else $error("full flag lost");
  chk_ready_clear:
    assert property (!load_enable_out && !$past(load_enable_out) |->
      !ram_full_out)
    else $error("counter not ready");
  chk_soft_pulse:
    assert property (soft_reset_out && !ctl_wr |=>
      !soft_reset_out && $stable(ram_execute_select_out))
    else $error("soft reset pulse wrong");
endmodule

// ### verification/host_model.sv
// Host microcontroller model issuing port transactions
`timescale 1ns/1ps

module host_model
(
  // Clock and answer
  input  wire       clk_in,
  input  wire       acc_ready_in,
  input  wire [7:0] rd_data_in,
  // Request
  output reg        acc_valid_out,
  output reg        acc_write_out,
  output reg  [5:0] acc_addr_out,
  output reg  [7:0] acc_wdata_out
);
  // ****
  // One transfer, held until taken
  // ****
  initial
  begin
    acc_valid_out = 1'b0;
    acc_write_out = 1'b0;
    acc_addr_out  = 6'h00;
    acc_wdata_out = 8'h00;
  end

  // Parked bus is inverted so a stale value never passes for live
  task xfer(input w, input [5:0] a, input [7:0] d, output [7:0] r);
  begin
    @(negedge clk_in);
    acc_valid_out = 1'b1;
    acc_write_out = w;
    acc_addr_out  = a;
    acc_wdata_out = (a == 6'h3F) ? {d[7:4], d[3] & ~d[2], d[2], 2'b00} : d;
    #1;
    while (!acc_ready_in)
    begin
      @(negedge clk_in);
      #1;
    end
    @(negedge clk_in);
    r = rd_data_in;
    acc_valid_out = 1'b0;
    acc_addr_out  = ~a;
    acc_wdata_out = ~d;
  end
  endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the program RAM loader
`timescale 1ns/1ps

module tb_top;
  // ****
  // Signals
  // ****
  reg         clk_in, rst_n_in, ram_ready_in, init_done_in;
  reg  [7:0]  fw_code_in, sig, r;
  wire        acc_valid_in, acc_write_in, acc_ready_out, rd_valid_out;
  wire        ram_we_out, ram_execute_select_out, load_enable_out;
  wire        soft_reset_out, ram_full_out;
  wire [5:0]  acc_addr_in;
  wire [7:0]  acc_wdata_in, rd_data_out, ram_data_out;
  wire [11:0] ram_addr_out;
  reg  [11:0] exp_addr;
  integer     n_mismatch, comparisons, pops, cyc, i;

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  program_ram_loader program_ram_loader_inst
  (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .acc_valid_in(acc_valid_in),
    .acc_write_in(acc_write_in), .acc_addr_in(acc_addr_in),
    .acc_wdata_in(acc_wdata_in), .acc_ready_out(acc_ready_out),
    .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
    .ram_we_out(ram_we_out), .ram_addr_out(ram_addr_out),
    .ram_data_out(ram_data_out), .ram_ready_in(ram_ready_in),
    .ram_execute_select_out(ram_execute_select_out),
    .load_enable_out(load_enable_out), .soft_reset_out(soft_reset_out),
    .init_done_in(init_done_in), .fw_code_in(fw_code_in),
    .ram_full_out(ram_full_out)
  );

  host_model host_model_inst
  (
    .clk_in(clk_in), .acc_ready_in(acc_ready_out), .rd_data_in(rd_data_out),
    .acc_valid_out(acc_valid_in), .acc_write_out(acc_write_in),
    .acc_addr_out(acc_addr_in), .acc_wdata_out(acc_wdata_in)
  );

  task check(input [47:0] nm, input [12:0] seen, input [12:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask

  task final_report;
  begin
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  function [7:0] misr(input [7:0] s, input [7:0] d);
    misr = {s[6:0], 1'b0} ^ (s[7] ? 8'h1D : 8'h00) ^ d;
  endfunction

  task x(input w, input [5:0] a, input [7:0] d);
    host_model_inst.xfer(w, a, d, r);
  endtask

  // RAM pops must walk 0,1,2.. with the fill pattern; hang guard last
  always @(posedge clk_in)
  begin
    cyc = cyc + 1;
    if (ram_we_out && ram_ready_in)
    begin
      check("raddr", ram_addr_out, exp_addr);
      check("rdata", ram_data_out, exp_addr[7:0] ^ 8'h5A);
      exp_addr = exp_addr + 1;
      pops = pops + 1;
    end
    if (cyc == 40000)
    begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
  end

  task t_regs;
  begin
    x(0, 6'h3F, 8'h00);
    check("ctrl", r, 0);
    check("ramsel", ram_execute_select_out, 0);
    x(1, 6'h05, 8'hA5);
    x(1, 6'h3E, 8'h77);
    x(0, 6'h05, 8'h00);
    check("device_register", r, 8'hA5);
    x(0, 6'h3E, 8'h00);
    check("fwrev", r, 0);
    $display("test regs done");
  end
  endtask

  // Stalled RAM: FIFO fills, reads slip in between fills
  task t_load;
  begin
    x(1, 6'h3F, 8'h04);
    check("ldon", load_enable_out, 1);
    ram_ready_in = 1'b0;
    sig = 8'h00;
    exp_addr = 0;
    pops = 0;
    for (i = 0; i < 16; i = i + 1)
    begin
      x(1, i[5:0] ^ 6'h15, i[7:0] ^ 8'h5A);
      sig = misr(sig, i[7:0] ^ 8'h5A);
    end
    x(0, 6'h3F, 8'h00);
    check("ctrl", r, 8'h04);
    x(0, 6'h12, 8'h00);
    check("sig", r, sig);
    fork
      begin
        repeat (4) @(negedge clk_in);
        #1 check("stall", acc_ready_out, 0);
        @(negedge clk_in);
        ram_ready_in = 1'b1;
      end
      x(1, 6'h3E, 8'h4A);
    join
    sig = misr(sig, 8'h4A);
    x(0, 6'h00, 8'h00);
    check("sig", r, sig);
    x(1, 6'h3F, 8'h00);
    // Seventeen pops at one per cycle need the FIFO a few more edges
    repeat (12) @(negedge clk_in);
    check("pops", pops, 17);
    x(0, 6'h3E, 8'h00);
    check("fwrev", r, 0);
    x(1, 6'h3F, 8'h04);
    x(0, 6'h00, 8'h00);
    check("sig", r, 0);
    x(1, 6'h3F, 8'h00);
    $display("test load done");
  end
  endtask

  task t_full;
  begin
    exp_addr = 0;
    pops = 0;
    x(1, 6'h3F, 8'h04);
    for (i = 0; i < 4100; i = i + 1)
      x(1, 6'h00, i[7:0] ^ 8'h5A);
    check("full", ram_full_out, 1);
    repeat (20) @(negedge clk_in);
    check("pops", pops, 4096);
    x(1, 6'h3F, 8'h00);
    @(negedge clk_in);
    check("full", ram_full_out, 0);
    $display("test full done");
  end
  endtask

  task t_exec;
  begin
    x(1, 6'h3F, 8'h08);
    check("ramsel", ram_execute_select_out, 1);
    check("ldon", load_enable_out, 0);
    x(1, 6'h00, 8'h01);
    repeat (2) @(negedge clk_in);
    check("ramsel", ram_execute_select_out, 1);
    x(0, 6'h05, 8'h00);
    check("device_register", r, 0);
    init_done_in = 1'b1;
    fw_code_in = 8'h5C;
    @(negedge clk_in);
    init_done_in = 1'b0;
    x(0, 6'h3E, 8'h00);
    check("fwrev", r, 8'h5C);
    rst_n_in = 1'b0;
    @(negedge clk_in);
    rst_n_in = 1'b1;
    check("ramsel", ram_execute_select_out, 0);
    x(0, 6'h3E, 8'h00);
    check("fwrev", r, 0);
    $display("test exec done");
  end
  endtask

  initial
  begin
    rst_n_in = 1'b0;
    ram_ready_in = 1'b1;
    init_done_in = 1'b0;
    fw_code_in = 8'h00;
    n_mismatch = 0;
    comparisons = 0;
    pops = 0;
    cyc = 0;
    exp_addr = 0;
    repeat (16) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_regs;
    t_load;
    t_full;
    t_exec;
    final_report;
  end
endmodule

bind program_ram_loader loader_monitor loader_monitor_inst
(
  .clk_in(clk_in), .rst_n_in(rst_n_in), .acc_valid_in(acc_valid_in),
  .acc_write_in(acc_write_in), .acc_addr_in(acc_addr_in),
  .acc_wdata_in(acc_wdata_in), .acc_ready_out(acc_ready_out),
  .rd_valid_out(rd_valid_out), .ram_we_out(ram_we_out),
  .ram_ready_in(ram_ready_in), .ram_addr_out(ram_addr_out),
  .load_enable_out(load_enable_out), .soft_reset_out(soft_reset_out),
  .ram_execute_select_out(ram_execute_select_out),
  .ram_full_out(ram_full_out)
);
